// >>> logic/src_consts.vh
// constants for the system reset controller: pulse qualifiers, delay counts, fuse codes
// assumes a 125 MHz system clock; included by the reset controller module src_reset_ctrl
//
// Summary of operation
// [RL1] while reset is active, I/O registers load initial values; fetch restarts at reset vector
// [RL2] any active source forces port reset state at once, without a clock (here power-on only; pin, brown-out and watchdog requests are clocked)
// [RL3] after all sources clear, internal reset stretches by fuse-selected delay count
// [RL4] four sources: power-on, external pin, watchdog expiry, brown-out
// [RL5] pin low longer than minimum width resets even clockless; short pulses may not (the pin qualifier here counts on clk_sys_i)
// [RL6] pin release starts delay count; reset leaves only after the time-out
// [RL7] watchdog expiry while watchdog enabled causes a reset
// [RL8] power-on holds reset below level, starts delay above it, reasserts at once
// [RL9] three-bit brown-out level fuse: 111 off, other codes pick trigger level
// [RL10] enabled brown-out detector below lower level asserts reset immediately
// [RL11] brown-out indication must persist the qualification time before it resets
// [RL12] supply back above upper level runs delay count before reset release
// [RL13] enabled watchdog stays enabled and running in every sleep mode
// [RL14] sleep with I/O and ADC clocks stopped disables input buffers except wake-up pins
// [RL15] per-pin digital input disable bits block that pin's input buffer
// [RL16] debug fuse programmed keeps main clock source running in all sleep modes
// [RL17] watchdog gives one-cycle reset pulse; delay starts at its falling edge
// [RL18] each source sets its flag; power-on clears others; software writes zero to clear
// [RL19] reset request is OR of sources; reassertion during delay restarts count from zero
`ifndef SRC_CONSTS_VH
`define SRC_CONSTS_VH

`define SRC_CLK_MHZ          125
`define SRC_PIN_MIN_NS       400
`define SRC_PIN_MIN_CYC      ((`SRC_PIN_MIN_NS * `SRC_CLK_MHZ + 999) / 1000)
`define SRC_BOD_MIN_US       2
`define SRC_BOD_MIN_CYC      (`SRC_BOD_MIN_US * `SRC_CLK_MHZ)
`define SRC_BOD_OFF          3'b111
`define SRC_FLAG_WDOG        3
`define SRC_FLAG_BOD         2
`define SRC_FLAG_PIN         1
`define SRC_FLAG_POR         0
`define SRC_TOUT_SHORT_CYC   16
`define SRC_TOUT_MID_CYC     512
`define SRC_TOUT_LONG_CYC    4096
`define SRC_TOUT_XLONG_CYC   8192

`endif

// >>> logic/src_qualify.v
// qualifies an active-high request: it must stay active for MIN_CYC clocks before it counts
// assumes the input is synchronous to clk_sys_i
`timescale 1ns/10ps
module src_qualify #(
    parameter MIN_CYC = 50,
    parameter CW      = 12
) (
    input  wire clk_sys_i,   // system clock
    input  wire rstn_i,      // async reset, active low
    input  wire req_i,       // raw request, active high
    output wire hit_o        // request held long enough
);
    reg [CW-1:0] cnt_reg;
    reg          hit_reg;

    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= {CW{1'b0}};
            hit_reg <= 1'b0;
        end else if (!req_i) begin
            cnt_reg <= {CW{1'b0}};
            hit_reg <= 1'b0;
        end else if (cnt_reg == MIN_CYC[CW-1:0] - 1'b1) begin
            hit_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign hit_o = hit_reg;
endmodule // src_qualify

// >>> logic/src_delay.v
// stretches internal reset: counts the time-out after the request goes away
// restarts from zero whenever the request comes back
`timescale 1ns/10ps
module src_delay #(
    parameter CW = 16
) (
    input  wire          clk_sys_i,   // system clock
    input  wire          rstn_i,      // async reset, active low
    input  wire          req_i,       // combined reset request
    input  wire [CW-1:0] tout_i,      // time-out in cycles
    output wire          hold_o       // stretched reset, active high
);
    reg [CW-1:0] cnt_reg;
    reg          hold_reg;

    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg  <= {CW{1'b0}};
            hold_reg <= 1'b1;
        end else if (req_i) begin
            // [RL19] restart from zero
            cnt_reg  <= {CW{1'b0}};
            hold_reg <= 1'b1;
        end else if (hold_reg) begin
            // [RL3] time-out count
            if (cnt_reg >= tout_i - 1'b1)
                hold_reg <= 1'b0;
            else
                cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign hold_o = hold_reg;
endmodule // src_delay

// >>> logic/src_reset_ctrl.v
// system reset controller: merges power-on, pin, watchdog and brown-out into one reset
// assumes synchronous monitor inputs; rstn_i is the chip's power-up reset of this logic
`timescale 1ns/10ps
`include "src_consts.vh"
module src_reset_ctrl #(
    parameter NPIN = 16,
    parameter CW   = 16,
    parameter TOUT_XLONG = `SRC_TOUT_XLONG_CYC
) (
    input  wire            clk_sys_i,               // system clock
    input  wire            rstn_i,                  // async reset, active low
    input  wire            por_low_i,               // supply below power-on level
    input  wire            pin_rstn_i,              // external reset pin, active low
    input  wire            wdog_expire_i,           // watchdog period expired, pulse
    input  wire            wdog_en_i,               // watchdog enabled
    input  wire            bod_low_i,               // supply below lower brown-out level
    input  wire [2:0]      brownout_level_fuse_i,   // brown-out trigger level code
    input  wire [1:0]      startup_time_fuse_i,     // start-up time select
    input  wire [3:0]      clock_select_fuse_i,     // clock source select
    input  wire            debug_enable_fuse_i,     // on-chip debug enabled
    input  wire            sleep_i,                 // core is in a sleep mode
    input  wire            io_clk_stop_i,           // I/O clock stopped in sleep
    input  wire            adc_clk_stop_i,          // ADC clock stopped in sleep
    input  wire [NPIN-1:0] wake_pins_i,             // pins needed for wake-up
    input  wire [7:0]      input_disable_reg_lo_i,  // digital input disable, low pins
    input  wire [NPIN-9:0] input_disable_reg_hi_i,  // digital input disable, high pins
    input  wire [3:0]      flag_clr_i,              // write strobe: clear flag bits
    output wire            port_rst_o,              // asynchronous port reset, active high
    output wire            core_rst_o,              // stretched internal reset, active high
    output reg  [3:0]      reset_flags_o,           // watchdog, brown-out, pin, power-on
    output reg  [NPIN-1:0] inbuf_en_o,              // pin input buffer enables
    output reg  [2:0]      bod_sel_o,               // brown-out level code to comparator
    output reg             bod_en_o,                // brown-out detector enabled
    output reg             wdog_run_o,              // watchdog keeps running
    output reg             main_clk_keep_o          // main clock kept running in sleep
);
    wire pin_hit;
    wire bod_hit;
    wire pin_req;
    wire bod_req;
    wire wdog_pulse;
    wire any_req;
    wire hold;
    reg  [CW-1:0] tout;
    reg  [3:0]    flags_next;
    reg           wdog_pulse_reg;

    // time-out counts declared at counter width so the selector never truncates
    localparam [CW-1:0] T_SHORT = `SRC_TOUT_SHORT_CYC;
    localparam [CW-1:0] T_MID   = `SRC_TOUT_MID_CYC;
    localparam [CW-1:0] T_LONG  = `SRC_TOUT_LONG_CYC;
    localparam [CW-1:0] T_XLONG = TOUT_XLONG;

    // [RL5] pin pulse qualifier
    src_qualify #(.MIN_CYC(`SRC_PIN_MIN_CYC), .CW(12)) u_pin (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .req_i     (~pin_rstn_i),
        .hit_o     (pin_hit)
    );

    // [RL11] brown-out qualification
    src_qualify #(.MIN_CYC(`SRC_BOD_MIN_CYC), .CW(12)) u_bod (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .req_i     (bod_low_i & bod_en_o),
        .hit_o     (bod_hit)
    );

    // [RL9] fuse coding: 111 disables detection
    always @* begin
        bod_sel_o = brownout_level_fuse_i;
        bod_en_o  = (brownout_level_fuse_i != `SRC_BOD_OFF);
    end

    // [RL6] pin request persists until pin returns high
    assign pin_req = pin_hit & ~pin_rstn_i;
    // [RL10] immediate once qualified; [RL12] released when supply recovers
    assign bod_req = bod_hit & bod_low_i & bod_en_o;

    // [RL17] one-cycle watchdog reset pulse
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i)
            wdog_pulse_reg <= 1'b0;
        else
            wdog_pulse_reg <= wdog_expire_i & wdog_en_i & ~wdog_pulse_reg;
    end
    // [RL7] only when enabled
    assign wdog_pulse = wdog_pulse_reg;

    // [RL4] four sources; [RL19] OR of active sources
    assign any_req = por_low_i | pin_req | wdog_pulse | bod_req;

    // [RL2] ports reset at once, no clock needed for power-on; pin, brown-out and watchdog requests are clocked; [RL8] power-on without delay
    assign port_rst_o = ~rstn_i | por_low_i | pin_req | bod_req | wdog_pulse | hold;

    // [RL3] time-out from start-up and clock-select fuses
    always @* begin
        case (startup_time_fuse_i)
            2'b00:   tout = T_SHORT;
            2'b01:   tout = T_MID;
            2'b10:   tout = T_LONG;
            default: tout = T_XLONG;
        endcase
        // external clock options skip the long oscillator start-up
        if (clock_select_fuse_i == 4'h0)
            tout = T_SHORT;
    end

    // [RL17] delay counts once the pulse falls; [RL8] power-on starts delay
    src_delay #(.CW(CW)) u_delay (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .req_i     (any_req),
        .tout_i    (tout),
        .hold_o    (hold)
    );

    // [RL1] core and I/O registers held in reset, restart at reset vector on release
    assign core_rst_o = any_req | hold;

    // [RL18] status flags: set wins over clear
    always @* begin
        flags_next = reset_flags_o & ~flag_clr_i;
        if (por_low_i)
            flags_next = 4'h1;
        else begin
            if (wdog_pulse)
                flags_next[`SRC_FLAG_WDOG] = 1'b1;
            if (bod_req)
                flags_next[`SRC_FLAG_BOD] = 1'b1;
            if (pin_req)
                flags_next[`SRC_FLAG_PIN] = 1'b1;
        end
    end

    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i)
            reset_flags_o <= 4'h1;
        else
            reset_flags_o <= flags_next;
    end

    // [RL13] [RL14] [RL15] [RL16] sleep effects
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            inbuf_en_o      <= {NPIN{1'b1}};
            wdog_run_o      <= 1'b0;
            main_clk_keep_o <= 1'b0;
        end else begin
            // [RL13] enabled watchdog runs regardless of sleep
            wdog_run_o <= wdog_en_i;
            // [RL16] debug keeps clock in sleep
            main_clk_keep_o <= ~sleep_i | debug_enable_fuse_i;
            // [RL14] [RL15] buffer gating
            if (sleep_i & io_clk_stop_i & adc_clk_stop_i)
                inbuf_en_o <= wake_pins_i & ~{input_disable_reg_hi_i, input_disable_reg_lo_i};
            else
                inbuf_en_o <= ~{input_disable_reg_hi_i, input_disable_reg_lo_i};
        end
    end
endmodule // src_reset_ctrl

// >>> test/src_supply_model.sv
// supply monitors and reset pin driver
// bench calls hold(); changes land 1 ns after a clock edge
`timescale 1ns/10ps
module src_supply_model (
    input  wire clk_sys_i,     // system clock
    output reg  por_low_o,     // supply below power-on level
    output reg  pin_rstn_o,    // reset pin, pulled up when idle
    output reg  bod_low_o,     // supply below brown-out level
    output reg  wdog_expire_o  // watchdog expiry
);
    initial {por_low_o, pin_rstn_o, bod_low_o, wdog_expire_o} = 4'h4;
    // source 0 power-on, 1 pin, 2 brown-out, 3 watchdog; active for n edges
    task hold(input integer src, input integer n);
        integer i;
        begin
            @(posedge clk_sys_i) #1;
            case (src)
                0: por_low_o = 1'b1;
                1: pin_rstn_o = 1'b0;
                2: bod_low_o = 1'b1;
                default: wdog_expire_o = 1'b1;
            endcase
            for (i = 0; i < n; i = i + 1) @(posedge clk_sys_i);
            #1 {por_low_o, pin_rstn_o, bod_low_o, wdog_expire_o} = 4'h4;
        end
    endtask
endmodule // src_supply_model

// >>> test/src_reset_ctrl_chk.sv
// port assertions for the reset controller
// bound to src_reset_ctrl; time-out is never below 16 cycles
`timescale 1ns/10ps
module src_reset_ctrl_chk #(parameter NPIN = 16) (
    input wire clk_sys_i, rstn_i, por_low_i, pin_rstn_i, wdog_expire_i, wdog_en_i, bod_low_i,
    input wire [2:0] brownout_level_fuse_i, bod_sel_o,
    input wire debug_enable_fuse_i, sleep_i, io_clk_stop_i, adc_clk_stop_i,
    input wire [NPIN-1:0] wake_pins_i, inbuf_en_o,
    input wire [7:0] input_disable_reg_lo_i,
    input wire [NPIN-9:0] input_disable_reg_hi_i,
    input wire port_rst_o, core_rst_o, bod_en_o, wdog_run_o, main_clk_keep_o,
    input wire [3:0] reset_flags_o
);
    reg [8:0] pin_cnt, bod_cnt;
    reg [15:0] q_cnt;
    wire deep = sleep_i & io_clk_stop_i & adc_clk_stop_i;
    wire quiet = ~por_low_i & pin_rstn_i & ~bod_low_i & ~(wdog_expire_i & wdog_en_i);
    // saturating run lengths, so long runs never wrap back
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_cnt <= 9'h0;
            bod_cnt <= 9'h0;
            q_cnt <= 16'h0;
        end else begin
            pin_cnt <= pin_rstn_i ? 9'h0 : pin_cnt + {8'h0, ~&pin_cnt};
            bod_cnt <= (bod_low_i & bod_en_o) ? bod_cnt + {8'h0, ~&bod_cnt} : 9'h0;
            q_cnt <= quiet ? q_cnt + {15'h0, ~&q_cnt} : 16'h0;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    property p_por; por_low_i |-> core_rst_o && port_rst_o; endproperty
    a_por: assert property (p_por) else $error("power-on low without reset");
    property p_pin; pin_cnt >= 9'd52 |-> core_rst_o && port_rst_o; endproperty
    a_pin: assert property (p_pin) else $error("long pin low without reset");
    property p_pin_flag; pin_cnt == 9'd52 |-> ##[0:2] reset_flags_o[1]; endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");
    property p_bod; bod_cnt >= 9'd252 |-> core_rst_o; endproperty
    a_bod: assert property (p_bod) else $error("brown-out without reset");
    property p_wdog; wdog_expire_i && wdog_en_i |-> ##[1:2] core_rst_o; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog without reset");
    property p_fuse; bod_en_o == (brownout_level_fuse_i != 3'h7) && bod_sel_o == brownout_level_fuse_i; endproperty
    a_fuse: assert property (p_fuse) else $error("level fuse decode wrong");
    property p_stretch; $fell(core_rst_o) |-> q_cnt >= 16'd16; endproperty
    a_stretch: assert property (p_stretch) else $error("reset left too early");
    property p_dis; 1'b1 |=> (inbuf_en_o & $past({input_disable_reg_hi_i, input_disable_reg_lo_i})) == 0; endproperty
    a_dis: assert property (p_dis) else $error("disabled buffer on");
    property p_deep; deep |=> (inbuf_en_o & ~$past(wake_pins_i)) == 0; endproperty
    a_deep: assert property (p_deep) else $error("buffer on in deep sleep");
    property p_wrun; wdog_en_i |=> wdog_run_o; endproperty
    a_wrun: assert property (p_wrun) else $error("watchdog stopped");
    property p_keep; debug_enable_fuse_i && sleep_i |=> main_clk_keep_o; endproperty
    a_keep: assert property (p_keep) else $error("main clock dropped");
    c_pin: cover property (pin_cnt == 9'd52);
    c_bod: cover property (bod_cnt == 9'd252);
    c_deep: cover property (deep && debug_enable_fuse_i);
endmodule // src_reset_ctrl_chk
bind src_reset_ctrl src_reset_ctrl_chk #(.NPIN(NPIN)) u_chk (.*);

// >>> test/src_reset_ctrl_test.sv
// self-checking bench for the reset controller
// sources come from src_supply_model; tout is measured from each release
`timescale 1ns/10ps
module src_reset_ctrl_test;
    reg clk = 0, rstn = 0, wen = 0, dbg = 0, slp = 0, ios = 0, adcs = 0;
    reg [2:0] bf = 3'h7;
    reg [1:0] startup_time_fuse = 2'h0;
    reg [3:0] cks = 4'h1, clr = 4'h0;
    reg [15:0] wake = 16'h0, dis = 16'h0;
    reg [31:0] lfsr = 32'hf876ed53;
    wire por, pin, bod, wx, prst, crst, ben, wrun, keep;
    wire [3:0] flags;
    wire [15:0] inb;
    wire [2:0] bsel;
    integer fail_count = 0, n_compared = 0, i, n, ef = 1;
    integer touts[$] = '{16, 512, 4096, 64, 16};
    always #4 clk = ~clk;
    src_supply_model u_sup (.clk_sys_i(clk), .por_low_o(por), .pin_rstn_o(pin), .bod_low_o(bod), .wdog_expire_o(wx));
    src_reset_ctrl #(.TOUT_XLONG(64)) u_dut (.clk_sys_i(clk), .rstn_i(rstn), .por_low_i(por), .pin_rstn_i(pin),
        .wdog_expire_i(wx), .wdog_en_i(wen), .bod_low_i(bod), .brownout_level_fuse_i(bf),
        .startup_time_fuse_i(startup_time_fuse), .clock_select_fuse_i(cks), .debug_enable_fuse_i(dbg), .sleep_i(slp),
        .io_clk_stop_i(ios), .adc_clk_stop_i(adcs), .wake_pins_i(wake), .input_disable_reg_lo_i(dis[7:0]),
        .input_disable_reg_hi_i(dis[15:8]), .flag_clr_i(clr), .port_rst_o(prst), .core_rst_o(crst),
        .reset_flags_o(flags), .inbuf_en_o(inb), .bod_sel_o(bsel), .bod_en_o(ben), .wdog_run_o(wrun),
        .main_clk_keep_o(keep));
    task cmp(input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task complete_run;
        begin
            $display("compared %0d, mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // waits for the stretched reset to end and checks its length
    task rel(input integer t);
        integer c;
        begin
            c = 0;
            while (crst !== 1'b0 && c < 9000) begin
                @(posedge clk) #1;
                c = c + 1;
            end
            if (c >= 9000) begin
                fail_count = fail_count + 1;
                complete_run;
            end
            cmp(c >= t && c <= t + 4, 1);
        end
    endtask
    function [31:0] nxt(input [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    initial begin
        repeat (3) @(posedge clk);
        cmp({flags, prst, crst}, {ef[3:0], 2'h3});
        #1 rstn = 1;
        rel(16);
        clr = 4'hf;
        @(posedge clk) #1 clr = 4'h0;
        ef = 0;
        @(posedge clk) #1 cmp(flags, ef);
        u_sup.hold(1, 40);
        cmp(crst, 0);
        for (i = 0; i < 5; i = i + 1) begin
            startup_time_fuse = (i == 4) ? 2'h1 : i[1:0];
            cks = (i == 4) ? 4'h0 : 4'h1;
            u_sup.hold(1, 60);
            ef = ef | 2;
            cmp({flags, prst}, {ef[3:0], 1'b1});
            rel(touts[i]);
        end
        u_sup.hold(1, 60);
        repeat (10) @(posedge clk);
        u_sup.hold(0, 3);
        ef = 1;
        cmp(flags, ef);
        rel(16);
        u_sup.hold(3, 1);
        repeat (4) @(posedge clk);
        cmp(crst, 0);
        wen = 1;
        u_sup.hold(3, 1);
        // pulse is registered one edge after the expiry, its flag one edge later
        @(posedge clk) #1;
        ef = ef | 8;
        cmp({flags, crst}, {ef[3:0], 1'b1});
        rel(16);
        for (i = 0; i < 8; i = i + 1) begin
            bf = i;
            n = (i == 3) ? 200 : 300;
            u_sup.hold(2, n);
            cmp({ben, bsel, crst}, {i != 7, bf, i != 7 && n > 250});
            if (i != 7 && n > 250) begin
                ef = ef | 4;
                cmp(flags, ef);
                rel(16);
            end
        end
        for (i = 0; i < 8; i = i + 1) begin
            lfsr = nxt(lfsr);
            {slp, ios, adcs, dbg, wen} = lfsr[4:0] | ((i < 2) ? 5'h1c : 5'h0);
            {wake, dis} = nxt(lfsr);
            @(posedge clk) #1;
            cmp(inb, {(slp & ios & adcs) ? wake & ~dis : ~dis});
            cmp({wrun, keep}, {wen, ~slp | dbg});
        end
        complete_run;
    end
endmodule // src_reset_ctrl_test
